// ===== common/memmap_pkg.sv
package memmap_pkg;
	localparam int unsigned ADDR_W = 32;
	localparam int unsigned PTR_W = 13;
	localparam int unsigned BANK_SHIFT = 18;
	localparam int unsigned BANKS_DEF = 2;
	localparam logic [ADDR_W-1:0] EXT_LAST = 32'h7fff_ffff;
	localparam logic [ADDR_W-1:0] PERIPH_BASE = 32'hb000_0000;
	localparam logic [ADDR_W-1:0] PERIPH_SIZE = 32'h0c00_0000;
	localparam logic [PTR_W-1:0] BOOT_PTR = 13'h0000;
	localparam logic [PTR_W-1:0] BOOT_UNITS = 13'h0010;
	localparam logic BOOT_RST = 1'b1;
	typedef enum logic [1:0] {
		REG_EXT,
		REG_PERIPH,
		REG_RSVD
	} region_t;
endpackage

// ===== logic/bank_match.sv
`timescale 1ns/1ps
module bank_match
	import memmap_pkg::*;
#(
	parameter int unsigned SIZE_W = memmap_pkg::PTR_W
) (
	input wire logic [memmap_pkg::ADDR_W-1:0] addr,
	input wire logic [memmap_pkg::PTR_W-1:0] base_ptr,
	input wire logic [SIZE_W-1:0] size_units,
	output logic hit
);
	import memmap_pkg::*;

	logic [ADDR_W:0] start_w;
	logic [ADDR_W:0] end_w;
	logic [ADDR_W:0] addr_w;

	if (SIZE_W < 1 || SIZE_W + BANK_SHIFT > ADDR_W) begin : g_bad_size
		$error("bank_match: SIZE_W out of range");
	end

	// start is pointer times 256 KB, end is exclusive
	assign start_w = (ADDR_W+1)'({base_ptr, {BANK_SHIFT{1'b0}}});
	assign end_w = start_w + (ADDR_W+1)'({size_units, {BANK_SHIFT{1'b0}}});
	assign addr_w = {1'b0, addr};
	assign hit = (size_units != '0) && (addr_w >= start_w) && (addr_w < end_w);
endmodule

// ===== logic/memmap_decoder.sv
`timescale 1ns/1ps
// Notes on behaviour
// [R1] low 2 GB decodes to external memory
// [R2] 192 MB from b000_0000 is peripherals
// [R3] everything else reserved, selects nothing
// [R4] bank placement only from pointer and size
// [R5] software keeps consecutive banks non-overlapping
// [R6] banks use 13-bit pointer; peripherals fixed
// [R7] bank start is pointer shifted left 18
// [R8] external-memory address outside all banks raises abort
// [R9] boot fetch at zero hits boot bank
// [R10] at most one select, none when reserved
module memmap_decoder
	import memmap_pkg::*;
#(
	parameter int unsigned BANKS = memmap_pkg::BANKS_DEF,
	parameter int unsigned SIZE_W = memmap_pkg::PTR_W,
	parameter int unsigned BOOT_BANK = 0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [memmap_pkg::ADDR_W-1:0] addr,
	input wire logic addr_valid,
	input wire logic [BANKS*memmap_pkg::PTR_W-1:0] sdram_bank_cfg_0,
	input wire logic [BANKS*SIZE_W-1:0] sdram_bank_cfg_1,
	input wire logic cfg_done,
	output logic [BANKS-1:0] bank_sel,
	output logic periph_sel,
	output logic reserved_hit,
	output logic abort,
	output logic sel_valid,
	output logic boot_mode
);
	import memmap_pkg::*;

	// boot window, used by the checks below
	localparam logic [ADDR_W-1:0] BOOT_START = ADDR_W'(BOOT_PTR) << BANK_SHIFT;
	localparam logic [ADDR_W-1:0] BOOT_SPAN = ADDR_W'(BOOT_UNITS) << BANK_SHIFT;

	if (BANKS < 1 || BOOT_BANK >= BANKS) begin : g_bad_banks
		$error("memmap_decoder: BANKS or BOOT_BANK out of range");
	end
	if (SIZE_W < 1 || SIZE_W + BANK_SHIFT > ADDR_W) begin : g_bad_size
		$error("memmap_decoder: SIZE_W out of range");
	end

	function automatic region_t region_of(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] off;
		off = a - PERIPH_BASE;
		if (a <= EXT_LAST) begin
			return REG_EXT;
		end else if (a >= PERIPH_BASE && off < PERIPH_SIZE) begin
			return REG_PERIPH;
		end else begin
			return REG_RSVD;
		end
	endfunction

	function automatic logic one_or_none(input logic [BANKS+1:0] v);
		return (v & (v - 1'b1)) == '0;
	endfunction

	logic boot_reg;
	logic boot_next;
	logic [BANKS-1:0] bank_sel_reg;
	logic [BANKS-1:0] bank_sel_next;
	logic periph_reg;
	logic periph_next;
	logic rsvd_reg;
	logic rsvd_next;
	logic abort_reg;
	logic abort_next;
	logic valid_reg;
	logic valid_next;

	region_t region_w;
	logic [BANKS-1:0] raw_hit;
	logic [BANKS-1:0] first_hit;
	logic ext_w;
	logic any_hit;

	assign region_w = region_of(addr);
	assign ext_w = (region_w == REG_EXT); // [R1]

	genvar g;
	generate
		for (g = 0; g < BANKS; g++) begin : gen_bank
			logic [PTR_W-1:0] ptr_w;
			logic [SIZE_W-1:0] size_w;
			// while booting only the boot bank maps, at fixed place
			assign ptr_w = boot_reg ? BOOT_PTR : sdram_bank_cfg_0[g*PTR_W +: PTR_W]; // [R4] [R6] [R9]
			assign size_w = boot_reg ? ((g == BOOT_BANK) ? SIZE_W'(BOOT_UNITS) : '0)
				: sdram_bank_cfg_1[g*SIZE_W +: SIZE_W]; // [R4] [R9]
			bank_match #(.SIZE_W(SIZE_W)) u_match (
				.addr(addr),
				.base_ptr(ptr_w),
				.size_units(size_w),
				.hit(raw_hit[g]) // [R7]
			);
		end
	endgenerate

	// overlap is illegal setup; lowest bank still wins so select stays one-hot
	assign first_hit = raw_hit & (~raw_hit + 1'b1); // [R5] [R10]
	assign any_hit = |raw_hit;

	assign bank_sel_next = (addr_valid && ext_w) ? first_hit : '0; // [R1] [R10]
	assign periph_next = addr_valid && (region_w == REG_PERIPH); // [R2] [R6]
	assign rsvd_next = addr_valid && (region_w == REG_RSVD); // [R3]
	assign abort_next = addr_valid && ((ext_w && !any_hit) || region_w == REG_RSVD); // [R8] [R3]
	assign valid_next = addr_valid;
	assign boot_next = boot_reg && !cfg_done;

	always_ff @(posedge clk) begin
		if (rst) begin
			boot_reg <= BOOT_RST; // [R9]
			bank_sel_reg <= '0;
			periph_reg <= 1'b0;
			rsvd_reg <= 1'b0;
			abort_reg <= 1'b0;
			valid_reg <= 1'b0;
		end else begin
			boot_reg <= boot_next;
			bank_sel_reg <= bank_sel_next;
			periph_reg <= periph_next;
			rsvd_reg <= rsvd_next;
			abort_reg <= abort_next;
			valid_reg <= valid_next;
		end
	end

	assign bank_sel = bank_sel_reg;
	assign periph_sel = periph_reg;
	assign reserved_hit = rsvd_reg;
	assign abort = abort_reg;
	assign sel_valid = valid_reg;
	assign boot_mode = boot_reg;

	a_ext_region: assert property (@(posedge clk) disable iff (rst) // [R1]
		addr_valid && addr <= EXT_LAST |=> !periph_sel && !reserved_hit)
		else $error("external address selected non-external region");

	a_periph_region: assert property (@(posedge clk) disable iff (rst) // [R2]
		addr_valid && addr >= PERIPH_BASE && (addr - PERIPH_BASE) < PERIPH_SIZE
		|=> periph_sel && bank_sel == '0 && !abort)
		else $error("peripheral address not routed to peripherals");

	a_rsvd_nosel: assert property (@(posedge clk) disable iff (rst) // [R3]
		reserved_hit |-> bank_sel == '0 && !periph_sel && abort)
		else $error("reserved address selected a target");

	a_rsvd_gap: assert property (@(posedge clk) disable iff (rst) // [R3]
		addr_valid && addr > EXT_LAST && addr < PERIPH_BASE |=> reserved_hit)
		else $error("gap below peripherals not reserved");

	a_bank_start: assert property (@(posedge clk) disable iff (rst) // [R7]
		addr_valid && !boot_reg && sdram_bank_cfg_1[SIZE_W-1:0] != '0
		&& addr == {1'b0, sdram_bank_cfg_0[PTR_W-1:0], {BANK_SHIFT{1'b0}}}
		|=> bank_sel[0])
		else $error("bank 0 start address not selecting bank 0");

	a_below_start: assert property (@(posedge clk) disable iff (rst) // [R4]
		addr_valid && !boot_reg && sdram_bank_cfg_0[PTR_W-1:0] != '0
		&& addr == {1'b0, sdram_bank_cfg_0[PTR_W-1:0], {BANK_SHIFT{1'b0}}} - 1'b1
		|=> !bank_sel[0])
		else $error("byte below bank start selected bank");

	a_abort_miss: assert property (@(posedge clk) disable iff (rst) // [R8]
		sel_valid && !periph_sel |-> abort == (bank_sel == '0))
		else $error("abort does not match missing bank select");

	a_boot_fetch: assert property (@(posedge clk) disable iff (rst) // [R9]
		boot_mode && addr_valid && addr == '0 |=> bank_sel[BOOT_BANK] && !abort)
		else $error("first fetch after reset missed boot bank");

	a_boot_hold: assert property (@(posedge clk) disable iff (rst) // [R9]
		boot_mode && !cfg_done |=> boot_mode)
		else $error("boot mode left without cfg_done");

	a_one_select: assert property (@(posedge clk) disable iff (rst) // [R10]
		one_or_none({bank_sel, periph_sel, reserved_hit}) && (sel_valid || !abort))
		else $error("more than one select driven");

	a_idle_quiet: assert property (@(posedge clk) disable iff (rst) // [R10]
		!addr_valid |=> !sel_valid && bank_sel == '0 && !periph_sel
		&& !reserved_hit && !abort)
		else $error("select driven without a transfer");

	a_valid_flag: assert property (@(posedge clk) disable iff (rst) // [R10]
		addr_valid |=> sel_valid)
		else $error("transfer result not flagged valid");

	a_boot_window: assert property (@(posedge clk) disable iff (rst) // [R9]
		boot_mode && addr_valid && (addr - BOOT_START) < BOOT_SPAN
		|=> bank_sel[BOOT_BANK] && !abort)
		else $error("boot window missed boot bank");

	a_boot_outside: assert property (@(posedge clk) disable iff (rst) // [R4]
		boot_mode && addr_valid && (addr - BOOT_START) >= BOOT_SPAN && addr <= EXT_LAST
		|=> bank_sel == '0 && abort)
		else $error("bank programming used while booting");

	a_periph_end: assert property (@(posedge clk) disable iff (rst) // [R2]
		addr_valid && addr >= PERIPH_BASE + PERIPH_SIZE |=> reserved_hit && !periph_sel)
		else $error("address above peripherals not reserved");

	a_bank_end: assert property (@(posedge clk) disable iff (rst) // [R4]
		addr_valid && !boot_reg
		&& addr == ADDR_W'({sdram_bank_cfg_0[PTR_W-1:0], {BANK_SHIFT{1'b0}}})
		+ ADDR_W'({sdram_bank_cfg_1[SIZE_W-1:0], {BANK_SHIFT{1'b0}}})
		|=> !bank_sel[0])
		else $error("byte at bank end selected bank");

	a_abort_clear: assert property (@(posedge clk) disable iff (rst) // [R8]
		bank_sel != '0 |-> !abort)
		else $error("abort raised on a bank hit");

	c_bank_hit: cover property (@(posedge clk) disable iff (rst)
		!boot_mode && sel_valid && bank_sel != '0);
	c_periph_hit: cover property (@(posedge clk) disable iff (rst) periph_sel);
	c_ext_abort: cover property (@(posedge clk) disable iff (rst)
		abort && !reserved_hit);
	c_boot_exit: cover property (@(posedge clk) disable iff (rst)
		boot_mode ##1 !boot_mode);
	c_rsvd_hit: cover property (@(posedge clk) disable iff (rst) reserved_hit);
endmodule

// ===== verif/bus_master_model.sv
`timescale 1ns/1ps
module bus_master_model (
	input wire logic clk,
	input wire logic [31:0] req_addr,
	input wire logic req,
	output logic [31:0] addr,
	output logic addr_valid
);
	// released bus inverts addr every cycle, alternating between the last address and its inverse
	always_ff @(posedge clk) begin
		addr <= req ? req_addr : ~addr;
		addr_valid <= req;
	end
endmodule

// ===== verif/test_memmap_decoder.sv
`timescale 1ns/1ps
module test_memmap_decoder;
	import memmap_pkg::*;
	logic clk = 0, rst = 1, req = 0, cfg_done = 0, boot_exp = 1;
	logic [31:0] req_addr = 0, addr, a;
	logic [25:0] ptrs = 0, sizes = 0;
	logic [1:0] bank_sel;
	logic periph_sel, reserved_hit, abort, sel_valid, boot_mode, addr_valid;
	logic [4:0] q[$];
	logic [4:0] e;
	logic [12:0] p0, s0;
	logic [31:0] dir_addr[13] = '{32'h0, 32'h0010_0000, 32'h001f_ffff, 32'h0020_0000,
		32'h003f_ffff, 32'h0040_0000, 32'h7fff_ffff, 32'h8000_0000, 32'hafff_ffff,
		32'hb000_0000, 32'hbbff_ffff, 32'hbc00_0000, 32'hffff_ffff};
	int n_errors = 0, cmp_count = 0;
	initial forever #2.5 clk = ~clk;
	bus_master_model i_bus_master_model(.clk(clk), .req_addr(req_addr), .req(req),
		.addr(addr), .addr_valid(addr_valid));
	memmap_decoder i_memmap_decoder(.clk(clk), .rst(rst), .addr(addr),
		.addr_valid(addr_valid), .sdram_bank_cfg_0(ptrs), .sdram_bank_cfg_1(sizes),
		.cfg_done(cfg_done), .bank_sel(bank_sel), .periph_sel(periph_sel),
		.reserved_hit(reserved_hit), .abort(abort), .sel_valid(sel_valid),
		.boot_mode(boot_mode));
	function automatic logic [4:0] model(input logic [31:0] x);
		logic [1:0] b;
		longint unsigned lo, hi;
		b = 0;
		for (int g = 1; g >= 0; g--) begin
			lo = 64'(boot_exp ? BOOT_PTR : ptrs[g*13 +: 13]) << BANK_SHIFT;
			hi = lo + (64'(boot_exp ? BOOT_UNITS : sizes[g*13 +: 13]) << BANK_SHIFT);
			if ((!boot_exp || g == 0) && x >= lo && x < hi) b = 2'b1 << g;
		end
		if (x <= EXT_LAST) return {b, 2'b00, b == 2'b00};
		if (x >= PERIPH_BASE && x - PERIPH_BASE < PERIPH_SIZE) return 5'b00100;
		return 5'b00011;
	endfunction
	task send(input logic [31:0] x);
		@(posedge clk);
		req <= 1'b1;
		req_addr <= x;
		q.push_back(model(x));
	endtask
	task idle(input int n);
		repeat (n) begin
			@(posedge clk);
			req <= 1'b0;
		end
	endtask
	task check(input logic v, input logic x);
		cmp_count++;
		if (v !== x) begin
			n_errors++;
			$display("[FAIL] %0t boot flag wrong", $time);
		end
	endtask
	task final_report;
		if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		wait (!rst);
		forever begin
			@(posedge clk);
			#1;
			e = (sel_valid === 1'b1 && q.size() != 0) ? q.pop_front() : 5'h0;
			cmp_count++;
			if ({bank_sel, periph_sel, reserved_hit, abort} !== e) begin
				n_errors++;
				$display("[FAIL] %0t decode mismatch, exp %b", $time, e);
			end
		end
	end
	initial begin
		void'($urandom(76));
		ptrs <= {13'd0, 13'h0ff};
		sizes <= {13'h3, 13'h7};
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		#1 check(boot_mode, 1'b1);
		send(0);
		send(32'h003f_ffff);
		send(32'h0040_0000);
		idle(3);
		cfg_done <= 1'b1;
		@(posedge clk);
		cfg_done <= 1'b0;
		boot_exp = 0;
		ptrs <= {13'd8, 13'd4};
		sizes <= {13'd8, 13'd4};
		#1 check(boot_mode, 1'b0);
		foreach (dir_addr[i]) send(dir_addr[i]);
		repeat (40) begin
			idle(2);
			p0 = 13'($urandom % 4096);
			s0 = 13'($urandom % 64);
			ptrs <= {p0 + s0 + 13'($urandom % 64), p0};
			sizes <= {13'($urandom % 64), s0};
			repeat (30) begin
				a = $urandom;
				if ($urandom % 2) a = {p0 + 13'($urandom % 200), 18'($urandom)};
				if ($urandom % 5 == 0) a = PERIPH_BASE + $urandom % 32'h0d00_0000;
				send(a);
				if ($urandom % 4 == 0) idle(1);
			end
		end
		idle(1);
		for (int i = 0; i < 10 && q.size() != 0; i++) @(posedge clk);
		rst <= 1'b1;
		idle(2);
		rst <= 1'b0;
		boot_exp = 1;
		#1 check(boot_mode, 1'b1);
		send(0);
		send(32'h0010_0000);
		send(32'h0040_0000);
		idle(1);
		for (int i = 0; i < 10 && q.size() != 0; i++) @(posedge clk);
		if (q.size() != 0) begin
			n_errors++;
			$display("[FAIL] %0t results missing", $time);
		end
		final_report();
	end
endmodule
